/* File: iscn_pkg.sv */
package iscn_pkg;

	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int WORD_W = 40;
	localparam int INSTR_W = 20;
	localparam int CHAR_W = 5;
	localparam int TETRAD_W = 4;
	localparam int SPACE_BIT = 4;
	localparam int RED_BIT = 19;
	localparam int GREEN_BIT = 15;
	localparam int DRUM_WORDS = 50;
	localparam logic [ADDR_W-1:0] ADDR_FIRST = 10'h000;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h3FF;
	localparam logic [ADDR_W-1:0] COUNTER_RESET = 10'h000;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_ACC_LO = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_ACC_HI = 8'h08;
	localparam logic [AXI_AW-1:0] OFF_RDBUF_LO = 8'h0C;
	localparam logic [AXI_AW-1:0] OFF_RDBUF_HI = 8'h10;
	localparam logic [AXI_AW-1:0] OFF_INSTR_LO = 8'h14;
	localparam logic [AXI_AW-1:0] OFF_INSTR_HI = 8'h18;
	localparam logic [AXI_AW-1:0] OFF_CTRL = 8'h1C;
	localparam int ST_GATE_BIT = 12;
	localparam int ST_RUN_BIT = 13;
	localparam int ST_LOAD_BIT = 14;
	localparam int ST_CLR_BIT = 15;
	localparam int ST_PEND_BIT = 16;
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam logic CTRL_HALT_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_LATCH, S_CHECK, S_EXEC, S_DRUM,
		S_LOAD_CLR, S_LOAD_RUN, S_LOAD_WR, S_LOAD_END
	} iscn_state_t;

endpackage

/* File: iscn_mem_if.sv */
interface iscn_mem_if;
	logic [iscn_pkg::ADDR_W-1:0] addr;
	logic we;
	logic [iscn_pkg::WORD_W-1:0] wdata;
	logic [iscn_pkg::WORD_W-1:0] rdata;
	logic clr_start;
	logic clr_busy;

	modport ctrl (output addr, we, wdata, clr_start, input rdata, clr_busy);
	modport mem (input addr, we, wdata, clr_start, output rdata, clr_busy);
endinterface

/* File: iscn_memory.sv */
module iscn_memory (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// sequencer side
	iscn_mem_if.mem mif
);

	logic [iscn_pkg::WORD_W-1:0] mem_q [0:(1<<iscn_pkg::ADDR_W)-1];
	logic [iscn_pkg::WORD_W-1:0] rdata_reg;
	logic clr_busy_reg, clr_busy_next;
	logic [iscn_pkg::ADDR_W-1:0] clr_addr_reg, clr_addr_next;

	assign mif.rdata = rdata_reg;
	assign mif.clr_busy = clr_busy_reg;

	// ----------------------------------------------------------------
	// clear walker
	// ----------------------------------------------------------------
	always_comb begin
		clr_busy_next = clr_busy_reg;
		clr_addr_next = clr_addr_reg;
		if (clr_busy_reg) begin
			clr_addr_next = clr_addr_reg + 1'b1;
			if (clr_addr_reg == iscn_pkg::ADDR_LAST)
				clr_busy_next = 1'b0;
		end else if (mif.clr_start) begin
			clr_busy_next = 1'b1;
			clr_addr_next = iscn_pkg::ADDR_FIRST;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clr_busy_reg <= 1'b0;
			clr_addr_reg <= iscn_pkg::ADDR_FIRST;
		end else begin
			clr_busy_reg <= clr_busy_next;
			clr_addr_reg <= clr_addr_next;
		end
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (clr_busy_reg)
			mem_q[clr_addr_reg] <= '0;
		else if (mif.we)
			mem_q[mif.addr] <= mif.wdata;
		rdata_reg <= mem_q[mif.addr];
	end

endmodule

/* File: iscn_sequencer.sv */
// Functional notes
// - ten-bit counter addresses next word, 000-3FF
// - transfer loads its address into counter
// - set-counter loads switches when stopped; lamps
// - drum transfer steps counter over fifty addresses
// - loaded words go to successive counter addresses
// - memory clear zeroes every word
// - gates select one instruction; two lamps show it
// - transfer sets gates; no manual gate setting
// - two adjacent spaces end loading
// - load switch on inhibits all execution
// - words pass reader buffer; accumulator sums them
// - load start zeroes instruction, buffer, accumulator
// - load end restores counter to start address
// - manual halts per instruction; automatic continues
// - start-next on left: go right, execute
// - start-next on right: fetch, increment, left, execute
// - perform-order repeats selected instruction
// - red/green breakpoint bits stop before execution
// - automatic start runs; perform executes current first
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module iscn_sequencer #(
	parameter int DRUM_WORDS = iscn_pkg::DRUM_WORDS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [iscn_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [iscn_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// operator panel
	input wire logic [iscn_pkg::ADDR_W-1:0] counter_switches,
	input wire logic set_counter,
	input wire logic mem_clear,
	input wire logic load_sw,
	input wire logic red_bp_sw,
	input wire logic green_bp_sw,
	input wire logic perform_order,
	input wire logic manual_mode,
	input wire logic start_next,
	output logic [iscn_pkg::ADDR_W-1:0] counter_lamps,
	output logic gate_left_lamp,
	output logic gate_right_lamp,
	// tape reader
	input wire logic rd_valid,
	input wire logic [iscn_pkg::CHAR_W-1:0] rd_char,
	output logic rd_ready,
	// arithmetic unit
	output logic exec_valid,
	output logic [iscn_pkg::INSTR_W-1:0] exec_instr,
	input wire logic exec_done,
	input wire logic exec_xfer,
	input wire logic [iscn_pkg::ADDR_W-1:0] exec_xfer_addr,
	input wire logic exec_xfer_right,
	input wire logic exec_drum,
	output logic drum_step,
	output logic [iscn_pkg::ADDR_W-1:0] drum_addr
);

	localparam int W = iscn_pkg::WORD_W;
	localparam int I = iscn_pkg::INSTR_W;
	localparam int A = iscn_pkg::ADDR_W;

	iscn_mem_if mif ();

	iscn_memory u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.mif(mif)
	);

	iscn_pkg::iscn_state_t state_reg, state_next;
	logic [A-1:0] cnt_reg, cnt_next, base_reg, base_next;
	logic [A-1:0] save_reg, save_next;
	logic gate_reg, gate_next, pend_reg, pend_next;
	logic [W-1:0] ir_reg, ir_next, rb_reg, rb_next, acc_reg, acc_next;
	logic [W-1:0] asm_reg, asm_next;
	logic last_sp_reg, last_sp_next;
	logic [5:0] drum_cnt_reg, drum_cnt_next;
	logic [I-1:0] instr_reg, instr_next;
	logic halt_reg, halt_next, soft_clr_reg, soft_clr_next;
	logic [I-1:0] sel;
	logic stop_now, bp_hit, after_gate;
	iscn_pkg::iscn_state_t fin_state;

	// ----------------------------------------------------------------
	// instruction selection
	// ----------------------------------------------------------------
	assign sel = gate_reg ? ir_reg[I-1:0] : ir_reg[W-1:I];
	assign bp_hit = (red_bp_sw && !sel[iscn_pkg::RED_BIT]) ||
		(green_bp_sw && !sel[iscn_pkg::GREEN_BIT]);
	assign stop_now = manual_mode || halt_reg || load_sw;
	assign after_gate = exec_xfer ? 1'b1 : gate_reg;
	assign fin_state = stop_now ? iscn_pkg::S_IDLE :
		(after_gate ? iscn_pkg::S_FETCH : iscn_pkg::S_CHECK);

	assign counter_lamps = cnt_reg;
	assign gate_right_lamp = gate_reg;
	assign gate_left_lamp = !gate_reg;
	assign exec_valid = state_reg == iscn_pkg::S_EXEC;
	assign exec_instr = instr_reg;
	assign drum_step = state_reg == iscn_pkg::S_DRUM;
	assign drum_addr = cnt_reg;
	assign rd_ready = state_reg == iscn_pkg::S_LOAD_RUN;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		base_next = base_reg;
		save_next = save_reg;
		gate_next = gate_reg;
		pend_next = pend_reg;
		ir_next = ir_reg;
		rb_next = rb_reg;
		acc_next = acc_reg;
		asm_next = asm_reg;
		last_sp_next = last_sp_reg;
		drum_cnt_next = drum_cnt_reg;
		instr_next = instr_reg;
		mif.addr = cnt_reg;
		mif.we = 1'b0;
		mif.wdata = rb_reg;
		mif.clr_start = 1'b0;
		unique case (state_reg)
			iscn_pkg::S_IDLE: begin
				if (mif.clr_busy) begin
					state_next = iscn_pkg::S_IDLE;
				end else if (load_sw) begin
					state_next = iscn_pkg::S_LOAD_CLR;
				end else if (mem_clear || soft_clr_reg) begin
					mif.clr_start = 1'b1;
				end else if (set_counter) begin
					cnt_next = counter_switches;
				end else if (perform_order) begin
					instr_next = sel;
					state_next = iscn_pkg::S_EXEC;
				end else if (start_next) begin
					gate_next = 1'b1;
					state_next = gate_reg ? iscn_pkg::S_FETCH :
						iscn_pkg::S_CHECK;
				end
			end
			iscn_pkg::S_FETCH: begin
				cnt_next = cnt_reg + 1'b1;
				gate_next = pend_reg;
				pend_next = 1'b0;
				state_next = iscn_pkg::S_LATCH;
			end
			iscn_pkg::S_LATCH: begin
				ir_next = mif.rdata;
				state_next = iscn_pkg::S_CHECK;
			end
			iscn_pkg::S_CHECK: begin
				instr_next = sel;
				state_next = bp_hit ? iscn_pkg::S_IDLE :
					iscn_pkg::S_EXEC;
			end
			iscn_pkg::S_EXEC: begin
				if (exec_done) begin
					if (exec_xfer) begin
						cnt_next = exec_xfer_addr;
						gate_next = 1'b1;
						pend_next = exec_xfer_right;
					end
					if (exec_drum && !exec_xfer) begin
						save_next = cnt_reg;
						drum_cnt_next = '0;
						state_next = iscn_pkg::S_DRUM;
					end else begin
						state_next = fin_state;
						if (!stop_now)
							gate_next = 1'b1;
					end
				end
			end
			iscn_pkg::S_DRUM: begin
				cnt_next = cnt_reg + 1'b1;
				drum_cnt_next = drum_cnt_reg + 1'b1;
				if (drum_cnt_reg == 6'(DRUM_WORDS - 1)) begin
					cnt_next = save_reg;
					state_next = fin_state;
					if (!stop_now)
						gate_next = 1'b1;
				end
			end
			iscn_pkg::S_LOAD_CLR: begin
				ir_next = '0;
				rb_next = '0;
				acc_next = '0;
				asm_next = '0;
				last_sp_next = 1'b0;
				base_next = cnt_reg;
				state_next = iscn_pkg::S_LOAD_RUN;
			end
			iscn_pkg::S_LOAD_RUN: begin
				if (rd_valid) begin
					if (rd_char[iscn_pkg::SPACE_BIT]) begin
						if (last_sp_reg) begin
							cnt_next = base_reg;
							state_next = iscn_pkg::S_LOAD_END;
						end else begin
							rb_next = asm_reg;
							asm_next = '0;
							last_sp_next = 1'b1;
							state_next = iscn_pkg::S_LOAD_WR;
						end
					end else begin
						asm_next = {asm_reg[W-iscn_pkg::TETRAD_W-1:0],
							rd_char[iscn_pkg::TETRAD_W-1:0]};
						last_sp_next = 1'b0;
					end
				end
			end
			iscn_pkg::S_LOAD_WR: begin
				mif.we = 1'b1;
				acc_next = acc_reg + rb_reg;
				cnt_next = cnt_reg + 1'b1;
				state_next = iscn_pkg::S_LOAD_RUN;
			end
			iscn_pkg::S_LOAD_END: begin
				if (!load_sw)
					state_next = iscn_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= iscn_pkg::S_IDLE;
			cnt_reg <= iscn_pkg::COUNTER_RESET;
			base_reg <= iscn_pkg::COUNTER_RESET;
			save_reg <= iscn_pkg::COUNTER_RESET;
			gate_reg <= 1'b1;
			pend_reg <= 1'b0;
			ir_reg <= '0;
			rb_reg <= '0;
			acc_reg <= '0;
			asm_reg <= '0;
			last_sp_reg <= 1'b0;
			drum_cnt_reg <= '0;
			instr_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			base_reg <= base_next;
			save_reg <= save_next;
			gate_reg <= gate_next;
			pend_reg <= pend_next;
			ir_reg <= ir_next;
			rb_reg <= rb_next;
			acc_reg <= acc_next;
			asm_reg <= asm_next;
			last_sp_reg <= last_sp_next;
			drum_cnt_reg <= drum_cnt_next;
			instr_reg <= instr_next;
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [iscn_pkg::AXI_AW-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic w_strb0_reg, w_strb0_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	function automatic logic [32:0] reg_read(
		input logic [iscn_pkg::AXI_AW-1:0] addr);
		logic [31:0] st;
		st = 32'h0000_0000;
		st[A-1:0] = cnt_reg;
		st[iscn_pkg::ST_GATE_BIT] = gate_reg;
		st[iscn_pkg::ST_RUN_BIT] = state_reg != iscn_pkg::S_IDLE;
		st[iscn_pkg::ST_LOAD_BIT] = load_sw;
		st[iscn_pkg::ST_CLR_BIT] = mif.clr_busy;
		st[iscn_pkg::ST_PEND_BIT] = pend_reg;
		case (addr)
			iscn_pkg::OFF_STATUS: reg_read = {1'b1, st};
			iscn_pkg::OFF_ACC_LO: reg_read = {1'b1, acc_reg[31:0]};
			iscn_pkg::OFF_ACC_HI: reg_read = {1'b1, 24'h00_0000, acc_reg[W-1:32]};
			iscn_pkg::OFF_RDBUF_LO: reg_read = {1'b1, rb_reg[31:0]};
			iscn_pkg::OFF_RDBUF_HI: reg_read = {1'b1, 24'h00_0000, rb_reg[W-1:32]};
			iscn_pkg::OFF_INSTR_LO: reg_read = {1'b1, ir_reg[31:0]};
			iscn_pkg::OFF_INSTR_HI: reg_read = {1'b1, 24'h00_0000, ir_reg[W-1:32]};
			iscn_pkg::OFF_CTRL: reg_read = {1'b1, 31'h0000_0000, halt_reg};
			default: reg_read = {1'b0, 32'h0000_0000};
		endcase
	endfunction

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	always_comb begin
		logic [32:0] rd;
		logic [32:0] wr_hit;
		rd = reg_read(s_axi_araddr);
		wr_hit = reg_read(aw_addr_reg);
		aw_got_next = aw_got_reg;
		aw_addr_next = aw_addr_reg;
		w_got_next = w_got_reg;
		w_data_next = w_data_reg;
		w_strb0_next = w_strb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		halt_next = halt_reg;
		soft_clr_next = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb0_next = s_axi_wstrb[0];
		end
		if (aw_got_reg && w_got_reg) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_hit[32] ? iscn_pkg::RESP_OKAY :
				iscn_pkg::RESP_SLVERR;
			if (aw_addr_reg == iscn_pkg::OFF_CTRL && w_strb0_reg) begin
				halt_next = w_data_reg[iscn_pkg::CTRL_HALT_BIT];
				soft_clr_next = w_data_reg[iscn_pkg::CTRL_CLEAR_BIT];
			end
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next = rd[31:0];
			rresp_next = rd[32] ? iscn_pkg::RESP_OKAY : iscn_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_got_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= iscn_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= iscn_pkg::RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			halt_reg <= iscn_pkg::CTRL_HALT_RESET;
			soft_clr_reg <= 1'b0;
		end else begin
			aw_got_reg <= aw_got_next;
			aw_addr_reg <= aw_addr_next;
			w_got_reg <= w_got_next;
			w_data_reg <= w_data_next;
			w_strb0_reg <= w_strb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			halt_reg <= halt_next;
			soft_clr_reg <= soft_clr_next;
		end
	end

endmodule

/* File: iscn_seq_monitor.sv */
module iscn_seq_monitor #(
	parameter int DRUM_WORDS = 50
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// panel and reader
	input wire logic load_sw,
	input wire logic [9:0] counter_lamps,
	input wire logic gate_left_lamp,
	input wire logic gate_right_lamp,
	input wire logic rd_ready,
	// arithmetic unit
	input wire logic exec_valid,
	input wire logic [19:0] exec_instr,
	input wire logic exec_done,
	input wire logic drum_step,
	input wire logic [9:0] drum_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	int run;

	// length of the current drum burst
	always_ff @(posedge aclk)
		if (!aresetn)
			run <= 0;
		else
			run <= drum_step ? run + 1 : 0;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	gate_onehot_a: assert property (
		gate_left_lamp != gate_right_lamp) else $error("gate lamps not one-hot");
	exec_hold_a: assert property (
		exec_valid && !exec_done |=> exec_valid && $stable(exec_instr))
		else $error("offered instruction dropped or changed");
	exec_counter_a: assert property (
		exec_valid && !exec_done |=> $stable(counter_lamps))
		else $error("counter moved during execution");
	load_inhibit_a: assert property (
		load_sw && $past(load_sw) |-> !exec_valid)
		else $error("execution while load switch up");
	reader_gate_a: assert property (
		rd_ready |-> load_sw) else $error("reader accepted outside load");
	drum_len_a: assert property (
		$fell(drum_step) |-> run == DRUM_WORDS) else $error("drum burst length");
	drum_addr_a: assert property (
		drum_step && $past(drum_step) |-> drum_addr == $past(drum_addr) + 10'h001)
		else $error("drum address not stepping");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	write_busy_a: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");

	cover property ($fell(drum_step));
	cover property (rd_ready && load_sw);
	cover property (exec_valid && gate_right_lamp);
endmodule

/* File: iscn_reader_model.sv */
module iscn_reader_model (
	// clock
	input wire logic aclk,
	// reader port
	input wire logic rd_ready,
	output logic rd_valid,
	output logic [4:0] rd_char
);
	timeunit 1ns;
	timeprecision 1ns;
	int stalls;
	logic hs;

	initial begin
		rd_valid = 1'b0;
		rd_char = 5'h1F;
		stalls = 0;
	end

	// one character, held until taken or for at most 200 cycles; called just after a rising edge
	task automatic send_char(input logic [4:0] c);
		int i;
		rd_valid <= 1'b1;
		rd_char <= c;
		hs = 1'b0;
		for (i = 0; i < 200 && !hs; i++) begin
			@(negedge aclk);
			hs = (rd_ready === 1'b1);
			@(posedge aclk);
		end
		if (!hs)
			stalls++;
		rd_valid <= 1'b0;
		rd_char <= ~c;
		@(posedge aclk);
	endtask

	// ten tetrads, high first, then the closing space
	task automatic send_word(input logic [39:0] w, input int gap);
		int k;
		for (k = 9; k >= 0; k--) begin
			send_char({1'b0, w[k*4 +: 4]});
			repeat (gap) @(posedge aclk);
		end
		send_char(5'h10);
	endtask

	// second adjacent space ends the tape
	task automatic send_end();
		send_char(5'h10);
	endtask
endmodule

/* File: iscn_sequencer_tb.sv */
module iscn_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DW = 4;
	localparam logic [39:0] W1 = 40'h88_0010_0002;
	localparam logic [39:0] W2 = 40'h00_00A8_8005;
	localparam logic [39:0] SUM = 40'h88_00B8_8007;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, set_c, mclr, load_sw, red_sw;
	logic green_sw, perf, manual, snext, left_l, right_l, rd_valid, rd_ready;
	logic ev, edone, exfer, eright, edrum, dstep;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [9:0] sw, lamps, xaddr, daddr;
	logic [4:0] rd_char;
	logic [19:0] einstr;
	int n_fail, total_checks;

	iscn_sequencer #(.DRUM_WORDS(DW)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .counter_switches(sw), .set_counter(set_c),
		.mem_clear(mclr), .load_sw(load_sw), .red_bp_sw(red_sw),
		.green_bp_sw(green_sw), .perform_order(perf), .manual_mode(manual),
		.start_next(snext), .counter_lamps(lamps), .gate_left_lamp(left_l),
		.gate_right_lamp(right_l), .rd_valid(rd_valid), .rd_char(rd_char),
		.rd_ready(rd_ready), .exec_valid(ev), .exec_instr(einstr),
		.exec_done(edone), .exec_xfer(exfer), .exec_xfer_addr(xaddr),
		.exec_xfer_right(eright), .exec_drum(edrum), .drum_step(dstep),
		.drum_addr(daddr)
	);
	iscn_reader_model rdr (.aclk(aclk), .rd_ready(rd_ready),
		.rd_valid(rd_valid), .rd_char(rd_char));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic lost();
		n_fail++;
		$display("unexpected at %0t: wait ran out, got %h expected %h", $time, 0, 1);
		give_verdict();
	endtask
	task automatic press(input int which);
		@(posedge aclk);
		case (which)
			0: snext <= 1'b1;
			1: perf <= 1'b1;
			2: set_c <= 1'b1;
			default: mclr <= 1'b1;
		endcase
		@(posedge aclk);
		{snext, perf, set_c, mclr} <= 4'h0;
	endtask
	task automatic wait_exec(input logic [19:0] exp);
		int i;
		for (i = 0; i < 50; i++) begin
			@(negedge aclk);
			if (ev === 1'b1)
				break;
		end
		if (ev !== 1'b1)
			lost();
		chk(einstr, exp);
	endtask
	task automatic fin(input logic x, input logic [9:0] a, input logic r,
		input logic d);
		@(posedge aclk);
		edone <= 1'b1;
		exfer <= x;
		xaddr <= a;
		eright <= r;
		edrum <= d;
		@(posedge aclk);
		{edone, exfer, edrum} <= 3'h0;
	endtask
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge aclk);
			seen |= ev;
		end
		chk({39'h0, seen}, 40'h0);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, tb;
		int i;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		for (i = 0; i < 40 && !tb; i++) begin
			@(negedge aclk);
			ta = awvalid & (awready === 1'b1);
			tw = wvalid & (wready === 1'b1);
			tb = (bvalid === 1'b1);
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!tb)
			lost();
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		int i;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (i = 0; i < 40 && !tr; i++) begin
			@(negedge aclk);
			ta = arvalid & (arready === 1'b1);
			tr = (rvalid === 1'b1);
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!tr)
			lost();
	endtask
	task automatic rd40(input logic [7:0] lo, output logic [39:0] v);
		logic [31:0] d0, d1;
		logic [1:0] r;
		axi_rd(lo, d0, r);
		axi_rd(lo + 8'h04, d1, r);
		v = {d1[7:0], d0};
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_clear();
		logic [31:0] d;
		logic [1:0] r;
		int i;
		press(3);
		axi_rd(iscn_pkg::OFF_STATUS, d, r);
		chk(d[iscn_pkg::ST_CLR_BIT], 1'b1);
		for (i = 0; i < 800 && d[iscn_pkg::ST_CLR_BIT] !== 1'b0; i++)
			axi_rd(iscn_pkg::OFF_STATUS, d, r);
		if (d[iscn_pkg::ST_CLR_BIT] !== 1'b0)
			lost();
		$display("test clear done");
	endtask
	task automatic t_load();
		logic [39:0] v;
		sw <= 10'h3FE;
		press(2);
		@(negedge aclk);
		chk(lamps, 10'h3FE);
		@(posedge aclk);
		load_sw <= 1'b1;
		rdr.send_word(W1, 0);
		rdr.send_word(W2, 2);
		rdr.send_end();
		press(0);
		quiet(6);
		rd40(iscn_pkg::OFF_ACC_LO, v);
		chk(v, SUM);
		rd40(iscn_pkg::OFF_RDBUF_LO, v);
		chk(v, W2);
		rd40(iscn_pkg::OFF_INSTR_LO, v);
		chk(v, 40'h0);
		chk({rdr.stalls[29:0], lamps}, {30'h0000_0000, 10'h3FE});
		@(posedge aclk);
		load_sw <= 1'b0;
		repeat (4) @(posedge aclk);
		$display("test load done");
	endtask
	task automatic t_step();
		press(0);
		wait_exec(20'h8_8001);
		chk({left_l, right_l, lamps}, {2'b10, 10'h3FF});
		fin(0, 0, 0, 0);
		quiet(4);
		press(1);
		wait_exec(20'h8_8001);
		chk({left_l, lamps}, {1'b1, 10'h3FF});
		fin(0, 0, 0, 0);
		red_sw <= 1'b1;
		press(0);
		quiet(8);
		chk({left_l, right_l}, 2'b01);
		press(1);
		wait_exec(20'h0_0002);
		fin(0, 0, 0, 0);
		red_sw <= 1'b0;
		green_sw <= 1'b1;
		press(0);
		quiet(8);
		chk({left_l, right_l, lamps}, {2'b10, 10'h000});
		press(0);
		wait_exec(20'h8_8005);
		fin(0, 0, 0, 0);
		green_sw <= 1'b0;
		$display("test step done");
	endtask
	task automatic t_xfer();
		press(0);
		wait_exec(20'h0_0000);
		fin(1, 10'h3FE, 1, 0);
		repeat (2) @(negedge aclk);
		chk(lamps, 10'h3FE);
		press(0);
		wait_exec(20'h0_0002);
		chk({left_l, right_l, lamps}, {2'b01, 10'h3FF});
		fin(0, 0, 0, 0);
		manual <= 1'b0;
		press(0);
		wait_exec(20'h0_000A);
		fin(0, 0, 0, 0);
		wait_exec(20'h8_8005);
		@(posedge aclk);
		manual <= 1'b1;
		fin(0, 0, 0, 0);
		quiet(6);
		chk({left_l, right_l, lamps}, {2'b01, 10'h000});
		$display("test transfer done");
	endtask
	task automatic t_drum();
		logic [9:0] first;
		int i, n;
		n = 0;
		press(0);
		wait_exec(20'h0_0000);
		fin(0, 0, 0, 1);
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			if (dstep === 1'b1 && n == 0)
				first = daddr;
			if (dstep === 1'b1)
				n++;
		end
		chk(n, DW);
		chk({first, lamps}, {10'h001, 10'h001});
		$display("test drum done");
	endtask
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(8'h40, d, r);
		chk({d, r}, {32'h0, iscn_pkg::RESP_SLVERR});
		axi_wr(8'h44, 32'h0000_0001, r);
		chk(r, iscn_pkg::RESP_SLVERR);
		axi_wr(iscn_pkg::OFF_CTRL, 32'h0000_0000, r);
		chk(r, iscn_pkg::RESP_OKAY);
		axi_rd(iscn_pkg::OFF_STATUS, d, r);
		chk(d[12:0], 13'h0001);
		$display("test bus done");
	endtask

	// ----------------------------------------------------------------
	// run
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial begin
		#2_000_000;
		lost();
	end
	initial begin
		n_fail = 0;
		total_checks = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = '0;
		{set_c, mclr, load_sw, red_sw, green_sw, perf, snext} = 7'h0;
		manual = 1'b1;
		{sw, xaddr, edone, exfer, eright, edrum} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({ev, rd_ready, left_l, right_l, lamps}, {4'b0001, 10'h0});
		t_clear();
		t_load();
		t_step();
		t_xfer();
		t_drum();
		t_bus();
		t_load();
		give_verdict();
	end
endmodule

bind iscn_sequencer iscn_seq_monitor #(.DRUM_WORDS(DRUM_WORDS)) mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.load_sw(load_sw), .counter_lamps(counter_lamps),
	.gate_left_lamp(gate_left_lamp), .gate_right_lamp(gate_right_lamp),
	.rd_ready(rd_ready), .exec_valid(exec_valid), .exec_instr(exec_instr),
	.exec_done(exec_done), .drum_step(drum_step), .drum_addr(drum_addr)
);
